//--- design/nrl_exec.sv
module nrl_exec (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // execution state
  output logic                    busy,
  output logic [3:0]              resultNibble,
  output logic                    zeroFlag,
  output logic                    carryFlag
);
  import nrl_pkg::*;

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------

  // zero test of a 4-bit result
  function automatic logic isZero(input logic [3:0] v);
    isZero = (v == 4'h0);
  endfunction

  // look-up rom content, constant table
  function automatic logic [3:0] lutRom(input logic [7:0] a);
    logic [7:0] t;
    t = a ^ LUT_SEED;
    lutRom = t[3:0] ^ t[7:4];
  endfunction

  // word address of working register w
  function automatic logic [6:0] wrAddr(input logic [3:0] w);
    wrAddr = {3'h0, w};
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [3:0]  mem_q [128];     // data memory
  logic [3:0]  mem_d [128];
  logic [3:0]  res_q,   res_d;    // result nibble register
  logic        zero_q,  zero_d;   // zero flag
  logic        carry_q, carry_d;  // carry flag
  logic [3:0]  lut_index_low_q, lut_index_low_d;  // lut index low
  logic [3:0]  lut_index_high_q, lut_index_high_d;  // lut index high
  logic [3:0]  lut_q,  lut_d;   // fetched table value
  logic [31:0] cmd_q,  cmd_d;   // latched command
  nrl_state_t  st_q,   st_d;    // execution state
  logic        busy_q, busy_d;  // busy output copy

  logic        wrPend_q, wrPend_d;  // write data phase pending
  logic        rdPend_q, rdPend_d;  // read data phase pending
  logic [9:0]  addr_q,  addr_d;     // captured byte address
  logic        rdy_q,   rdy_d;      // hreadyout
  logic [31:0] rdata_q, rdata_d;    // hrdata

  // bus strobes: accept feeds the bus group, wrDo the datapath
  logic        accept;   // address phase taken
  logic        wrDo;     // write data phase completes
  logic [2:0]  op;
  logic [6:0]  ra;
  logic [3:0]  imm;
  logic [3:0]  wa;

  assign accept = hsel & htrans[1] & hready;
  assign wrDo   = wrPend_q & hready;
  assign op     = cmd_q[OP_LSB +: 3];
  assign ra     = cmd_q[ADDR_LSB +: 7];
  assign imm    = cmd_q[IMM_LSB +: 4];
  assign wa     = cmd_q[ADDR_LSB +: 4];

  // -----------------------------------------------------------------
  // bus slave
  // -----------------------------------------------------------------

  // next values of the bus group: address capture, one read wait state
  always_comb begin
    wrPend_d = wrPend_q;
    rdPend_d = rdPend_q;
    addr_d   = addr_q;
    rdy_d    = rdy_q;
    rdata_d  = rdata_q;
    if (hready) begin
      // data phase ends, new address may be taken
      wrPend_d = accept & hwrite;
      rdPend_d = accept & ~hwrite;
      if (accept) begin
        addr_d = haddr[9:0];
      end
      // a read holds hreadyout low for one cycle
      if (accept && !hwrite) begin
        rdy_d = 1'b0;
      end
    end else if (rdPend_q) begin
      // read data lands with hreadyout
      rdy_d   = 1'b1;
      rdata_d = 32'h0;
      if (addr_q[9]) begin
        rdata_d[3:0] = mem_q[addr_q[8:2]];
      end else begin
        case (addr_q)
          REG_CMD: begin
            rdata_d = cmd_q;
          end
          REG_STATUS: begin
            rdata_d[ST_BUSY]        = busy_q;
            rdata_d[ST_ZERO]        = zero_q;
            rdata_d[ST_CARRY]       = carry_q;
            rdata_d[ST_RESULT +: 4] = res_q;
          end
          REG_RESULT: begin
            rdata_d[3:0]       = res_q;
            rdata_d[RES_ZERO]  = zero_q;
            rdata_d[RES_CARRY] = carry_q;
          end
          REG_TABLE: begin
            rdata_d[3:0]          = lut_index_low_q;
            rdata_d[TAB_HIGH +: 4] = lut_index_high_q;
          end
          // unmapped reads give zero
          default: begin
            rdata_d = 32'h0;
          end
        endcase
      end
    end
  end

  // bus group registers
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q   <= 10'h000;
      rdy_q    <= 1'b1;
      rdata_q  <= 32'h0;
    end else begin
      wrPend_q <= wrPend_d;
      rdPend_q <= rdPend_d;
      addr_q   <= addr_d;
      rdy_q    <= rdy_d;
      rdata_q  <= rdata_d;
    end
  end

  // -----------------------------------------------------------------
  // execution datapath
  // -----------------------------------------------------------------

  // next values of the datapath: bus writes while idle, then execution
  always_comb begin
    logic [3:0] r;
    r      = 4'h0;
    mem_d  = mem_q;
    res_d   = res_q;
    zero_d  = zero_q;
    carry_d = carry_q;
    lut_index_low_d = lut_index_low_q;
    lut_index_high_d = lut_index_high_q;
    lut_d  = lut_q;
    cmd_d  = cmd_q;
    st_d   = st_q;
    busy_d = busy_q;
    case (st_q)
      EX_IDLE: begin
        // software writes only take effect while idle
        if (wrDo) begin
          if (addr_q[9]) begin
            mem_d[addr_q[8:2]] = hwdata[3:0];
          end else begin
            case (addr_q)
              REG_CMD: begin
                cmd_d  = hwdata;
                st_d   = EX_RUN;
                busy_d = 1'b1;
              end
              REG_RESULT: begin
                res_d   = hwdata[3:0];
                zero_d  = hwdata[RES_ZERO];
                carry_d = hwdata[RES_CARRY];
              end
              REG_TABLE: begin
                lut_index_low_d = hwdata[3:0];
                lut_index_high_d = hwdata[TAB_HIGH +: 4];
              end
              // status and unmapped writes ignored
              default: begin
                st_d = EX_IDLE;
              end
            endcase
          end
        end
      end
      EX_RUN: begin
        st_d   = EX_IDLE;
        busy_d = 1'b0;
        case (op)
          OP_TABLE_READ: begin
            lut_d  = lutRom({lut_index_high_q, lut_index_low_q});
            st_d   = EX_TABLE_WRITE;
            busy_d = 1'b1;
          end
          OP_OR_MEM: begin
            r      = mem_q[ra] | res_q;
            res_d  = r;
            zero_d = isZero(r);
          end
          OP_OR_IMM: begin
            r      = mem_q[wrAddr(wa)] | imm;
            res_d  = r;
            zero_d = isZero(r);
          end
          OP_OR_MEM_WB: begin
            r         = mem_q[ra] | res_q;
            mem_d[ra] = r;
            res_d     = r;
            zero_d    = isZero(r);
          end
          OP_OR_IMM_WB: begin
            r                 = mem_q[wrAddr(wa)] | imm;
            mem_d[wrAddr(wa)] = r;
            res_d             = r;
            zero_d            = isZero(r);
          end
          OP_ROTATE: begin
            r         = {mem_q[ra][2:0], carry_q};
            carry_d   = mem_q[ra][3];
            mem_d[ra] = r;
            res_d     = r;
            zero_d    = isZero(r);
          end
          // unknown operations do nothing
          default: begin
            st_d = EX_IDLE;
          end
        endcase
      end
      EX_TABLE_WRITE: begin
        mem_d[ra] = lut_q;
        st_d      = EX_IDLE;
        busy_d    = 1'b0;
      end
      default: begin
        st_d   = EX_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // datapath registers
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) begin
        mem_q[i] <= MEM_RESET;
      end
      res_q   <= RESULT_RESET;
      zero_q  <= 1'b0;
      carry_q <= 1'b0;
      lut_index_low_q <= INDEX_RESET;
      lut_index_high_q <= INDEX_RESET;
      lut_q  <= 4'h0;
      cmd_q  <= 32'h0;
      st_q   <= EX_IDLE;
      busy_q <= 1'b0;
    end else begin
      mem_q  <= mem_d;
      res_q   <= res_d;
      zero_q  <= zero_d;
      carry_q <= carry_d;
      lut_index_low_q <= lut_index_low_d;
      lut_index_high_q <= lut_index_high_d;
      lut_q  <= lut_d;
      cmd_q  <= cmd_d;
      st_q   <= st_d;
      busy_q <= busy_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all from flip-flops except hresp, which is tied to 0
  // -----------------------------------------------------------------
  assign hreadyout    = rdy_q;
  assign hrdata       = rdata_q;
  assign hresp        = 1'b0;
  assign busy         = busy_q;
  assign resultNibble = res_q;
  assign zeroFlag     = zero_q;
  assign carryFlag    = carry_q;
endmodule

//--- design/nrl_pkg.sv
package nrl_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [9:0] REG_CMD     = 10'h000;  // command launch
  localparam logic [9:0] REG_STATUS  = 10'h004;  // busy, flags, result
  localparam logic [9:0] REG_RESULT  = 10'h008;  // result nibble and flags, writable
  localparam logic [9:0] REG_TABLE   = 10'h00c;  // look-up index pair
  localparam logic [9:0] MEM_BASE    = 10'h200;  // data memory window, one word a nibble

  // ---------------------------------------------------------------
  // command word fields
  // ---------------------------------------------------------------
  localparam int OP_LSB   = 0;   // 3-bit operation select
  localparam int ADDR_LSB = 4;   // 7-bit data memory address, low 4 bits pick a working reg
  localparam int IMM_LSB  = 12;  // 4-bit immediate

  // operation codes
  localparam logic [2:0] OP_TABLE_READ = 3'h0;
  localparam logic [2:0] OP_OR_MEM     = 3'h1;
  localparam logic [2:0] OP_OR_IMM     = 3'h2;
  localparam logic [2:0] OP_OR_MEM_WB  = 3'h3;
  localparam logic [2:0] OP_OR_IMM_WB  = 3'h4;
  localparam logic [2:0] OP_ROTATE     = 3'h5;

  // ---------------------------------------------------------------
  // status / result field positions
  // ---------------------------------------------------------------
  localparam int ST_BUSY  = 0;
  localparam int ST_ZERO  = 1;
  localparam int ST_CARRY = 2;
  localparam int ST_RESULT = 4;  // 4-bit result nibble
  localparam int RES_ZERO  = 4;  // zero flag in the result register
  localparam int RES_CARRY = 5;  // carry flag in the result register
  localparam int TAB_HIGH = 4;   // high index in the table register

  // ---------------------------------------------------------------
  // reset values and cycle counts
  // ---------------------------------------------------------------
  localparam logic [3:0] RESULT_RESET = 4'h0;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic [3:0] MEM_RESET   = 4'h0;
  localparam int TABLE_READ_CYCLES   = 2;
  localparam int SINGLE_CYCLES       = 1;
  localparam logic [7:0] LUT_SEED    = 8'h5a;  // arbitrary table content seed

  // execution states
  typedef enum logic [1:0] {
    EX_IDLE,
    EX_RUN,
    EX_TABLE_WRITE
  } nrl_state_t;
endpackage

//--- verification/nrl_exec_properties.sv
module nrl_exec_properties (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // bus side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // execution state
  input wire logic        busy,
  input wire logic [3:0]  resultNibble,
  input wire logic        zeroFlag,
  input wire logic        carryFlag
);
  // ---------------------------------------------------------------
  // launch tracking
  // ---------------------------------------------------------------
  logic        cmdPh_q, cmdPh_d;  // command write data phase
  logic [11:0] cap_q, cap_d;      // op, imm, result and carry at launch
  logic        go;                // command accepted
  assign go = cmdPh_q && !busy;
  // next values: capture operands when a command is accepted
  always_comb begin
    cmdPh_d = hsel && htrans[1] && hready && hwrite && (haddr[9:0] == 10'h000);
    cap_d   = go ? {hwdata[2:0], hwdata[15:12], resultNibble, carryFlag} : cap_q;
  end
  // registers only
  always_ff @(posedge clock) begin
    cmdPh_q <= rst ? 1'b0 : cmdPh_d;
    cap_q   <= cap_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_table_two: assert property (go && hwdata[2:0] == 3'h0 |=> busy [*2] ##1 !busy)
    else $error("table read busy length wrong");
  a_single_one: assert property (go && hwdata[2:0] inside {[3'h1:3'h5]} |=>
    busy ##1 !busy) else $error("single op busy length wrong");
  a_table_keeps: assert property (go && hwdata[2:0] == 3'h0 |-> ##3
    (resultNibble == cap_q[4:1] && carryFlag == cap_q[0]))
    else $error("table read changed result");
  a_or_mem_bits: assert property (go && hwdata[2:0] inside {3'h1, 3'h3} |-> ##2
    ((resultNibble & cap_q[4:1]) == cap_q[4:1])) else $error("memory or lost result bits");
  a_or_imm_bits: assert property (go && hwdata[2:0] inside {3'h2, 3'h4} |-> ##2
    ((resultNibble & cap_q[8:5]) == cap_q[8:5])) else $error("immediate or lost bits");
  a_rot_lsb: assert property (go && hwdata[2:0] == 3'h5 |-> ##2
    resultNibble[0] == cap_q[0]) else $error("rotate lsb not old carry");
  a_zero_match: assert property (go && hwdata[2:0] inside {[3'h1:3'h5]} |-> ##2
    zeroFlag == (resultNibble == 4'h0)) else $error("zero flag mismatch");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  c_table: cover property (go && hwdata[2:0] == 3'h0);
  c_rotate: cover property (go && hwdata[2:0] == 3'h5);
  c_dropped: cover property (cmdPh_q && busy);
  c_no_op: cover property (go && hwdata[2:0] == 3'h6);
endmodule

bind nrl_exec nrl_exec_properties i_props (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .busy(busy),
  .resultNibble(resultNibble), .zeroFlag(zeroFlag), .carryFlag(carryFlag));

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nrl_pkg::*;
  // ---------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------
  logic        clock, rst, hsel, hwrite, hreadyout, hresp, busy, zeroFlag, carryFlag;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0]  resultNibble;
  int          n_fail, n_compared, op, a, m, im, t, res, zro, cry, tl, th;
  int          mem [128];  // data memory model

  nrl_exec i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .busy(busy),
    .resultNibble(resultNibble), .zeroFlag(zeroFlag), .carryFlag(carryFlag));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bounded wait for hready at a rising edge
  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task bus(input logic [9:0] ad, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, ad};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // expected table content
  function int lut(int h, int l);
    logic [7:0] x;
    x = {h[3:0], l[3:0]} ^ LUT_SEED;
    return int'(x[3:0] ^ x[7:4]);
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
    hsize = 3'h2;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(42));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // reset values and an unmapped read
    bus(REG_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(MEM_BASE + 10'h1fc, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(10'h100, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // random memory contents
    for (int i = 0; i < 128; i++) begin
      mem[i] = $urandom_range(15);
      bus(MEM_BASE + 10'(4 * i), 1'b1, 32'(mem[i]));
    end
    // every operation in turn with random operands, code 6 is a no-op
    for (int i = 0; i < 63; i++) begin
      op = i % 7;
      a = $urandom_range(127);
      im = $urandom_range(15);
      {res, zro, cry, tl, th} = {32'($urandom_range(15)), 32'($urandom_range(1)),
        32'($urandom_range(1)), 32'($urandom_range(15)), 32'($urandom_range(15))};
      bus(REG_RESULT, 1'b1, 32'(cry * 32 + zro * 16 + res));
      bus(REG_TABLE, 1'b1, 32'(th * 16 + tl));
      bus(REG_CMD, 1'b1, 32'(im * 4096 + a * 16 + op));
      // back-to-back write during a table read is dropped
      if (op == 0) bus(REG_RESULT, 1'b1, 32'h3f);
      m = (op == 2 || op == 4) ? a % 16 : a;
      case (op)
        0: mem[m] = lut(th, tl);
        1, 3: res = mem[m] | res;
        2, 4: res = mem[m] | im;
        5: begin
          t = mem[m];
          res = (t * 2 + cry) % 16;
          cry = t / 8;
        end
        // no-op code leaves everything as it was
        default: t = 0;
      endcase
      if (op >= 3 && op <= 5) mem[m] = res;
      if (op >= 1 && op <= 5) zro = (res == 0);
      t = 0;
      do begin
        bus(REG_STATUS, 1'b0, 32'h0);
        t++;
      end while (rd[ST_BUSY] !== 1'b0 && t < 10);
      chk(rd, 32'(res * 16 + cry * 4 + zro * 2));
      chk(32'({hresp, busy, carryFlag, zeroFlag, resultNibble}),
        32'(cry * 32 + zro * 16 + res));
      bus(MEM_BASE + 10'(4 * m), 1'b0, 32'h0);
      chk(rd, 32'(mem[m]));
      bus(REG_TABLE, 1'b0, 32'h0);
      chk(rd, 32'(th * 16 + tl));
    end
    print_verdict();
  end
endmodule
